// ==== rtl/tcs_timer_regs.svh ====
// Register map, field positions, reset values and prescaler taps of the timer clock-select block.
// Assumes a 32-bit APB slave with byte addresses; each register takes one aligned word.
`ifndef TCS_TIMER_REGS_SVH
`define TCS_TIMER_REGS_SVH

// Word indices inside one channel (address bits 4..2); bit 5 of the address picks the channel.
`define TCS_OFF_CTRL      3'h0
`define TCS_OFF_CLKCTRL   3'h1
`define TCS_OFF_COUNT     3'h2
`define TCS_OFF_CMPA      3'h3
`define TCS_OFF_CMPB      3'h4
`define TCS_CH_BIT        5
`define TCS_ADDR_W        8

// Field positions of timer_control.
`define TCS_CTRL_IRQ_LSB  5
`define TCS_CTRL_CLR_LSB  3
`define TCS_CTRL_SRC_LSB  0

// Field positions of counter_clock_control.
`define TCS_CCC_LVL_BIT   3
`define TCS_CCC_ICK_LSB   0

// Reset values.
`define TCS_RST_CTRL      8'h00
`define TCS_RST_CLKCTRL   8'h00
`define TCS_RST_COUNT     8'h00
`define TCS_RST_CMP       8'hFF

// Prescaler taps as log2 of the divide ratio.
`define TCS_PRE_W         13
`define TCS_LOG_DIV2      4'h1
`define TCS_LOG_DIV8      4'h3
`define TCS_LOG_DIV32     4'h5
`define TCS_LOG_DIV64     4'h6
`define TCS_LOG_DIV1024   4'hA
`define TCS_LOG_DIV8192   4'hD

`endif

// ==== rtl/tcs_timer_pkg.sv ====
// Types shared by the timer clock-select block and its pin synchroniser.
// Assumes the constants of tcs_timer_regs.svh.
package tcs_timer_pkg;

   typedef enum logic [2:0] {
      TCS_SRC_NONE = 3'b000,
      TCS_SRC_INT1 = 3'b001,
      TCS_SRC_INT2 = 3'b010,
      TCS_SRC_INT3 = 3'b011,
      TCS_SRC_CASC = 3'b100,
      TCS_SRC_XRIS = 3'b101,
      TCS_SRC_XFAL = 3'b110,
      TCS_SRC_XBTH = 3'b111
   } tcs_src_e;

   typedef enum logic [1:0] {
      TCS_CLR_NONE = 2'b00,
      TCS_CLR_CMPA = 2'b01,
      TCS_CLR_CMPB = 2'b10,
      TCS_CLR_EXT  = 2'b11
   } tcs_clr_e;

   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } tcs_pin_s;

   typedef struct packed {
      logic [2:0] sh;
   } tcs_sync_s;

   typedef struct packed {
      logic [2:0] irq_en;
      tcs_clr_e clr_src;
      tcs_src_e clk_src;
      logic ext_lvl;
      logic [1:0] int_clk;
      logic [7:0] count;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic ovf;
      logic cma;
      logic cmb;
   } tcs_chan_s;

   typedef struct packed {
      logic [12:0] presc;
      tcs_chan_s [1:0] ch;
      logic [31:0] rdata;
   } tcs_state_s;

endpackage : tcs_timer_pkg

// ==== rtl/tcs_pin_sync.sv ====
// Two-flop synchroniser with edge detection for one pin.
// Assumes the pin is asynchronous to pclk and stays at each level for at least two pclk periods.
`timescale 1ns/1ns
`default_nettype none
module tcs_pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output tcs_timer_pkg::tcs_pin_s sync
);

   tcs_timer_pkg::tcs_sync_s s_q;
   tcs_timer_pkg::tcs_sync_s s_d;

   // Stage 0 is read only by stage 1; edges are taken between stages 1 and 2.
   always_comb begin
      s_d.sh = {s_q.sh[1:0], pin};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync.level = s_q.sh[1];
   assign sync.rise = s_q.sh[1] & ~s_q.sh[2];
   assign sync.fall = ~s_q.sh[1] & s_q.sh[2];

endmodule : tcs_pin_sync
`default_nettype wire

// ==== rtl/tcs_timer.sv ====
// Two 8-bit timer channels with clock-source selection, cascade and external clock and reset pins.
// Assumes an APB master on pclk; the external pins are asynchronous and slower than pclk / 4.
// How it works
// - Clock control bits 7..4 read zero.
// - Clock control bit 2 reads zero.
// - Reset select acts only when clear field 11.
// - Select 0: clear on reset rising edge.
// - Select 1: hold cleared while reset high.
// - Reset select exists only on these channels.
// - Internal select combines with clock-source code.
// - 000 stops; 001 divides by 8 or 2.
// - 010 divides by 64 or 32.
// - 011 divides by 8192 or 1024.
// - Channel 0 code 100 counts channel 1 overflows.
// - Channel 1 code 100 counts channel 0 match A.
// - Code 101 counts external pin rising edges.
// - Code 110 counts external pin falling edges.
// - Code 111 counts both external pin edges.
// - Clear field: none, match A, match B, external.
// - Clock-source code sits in control bits 2..0.
`include "tcs_timer_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tcs_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] ext_clk_pin,
   input wire logic [1:0] ext_rst_pin
);

   tcs_timer_pkg::tcs_state_s s_q;
   tcs_timer_pkg::tcs_state_s s_d;
   tcs_timer_pkg::tcs_pin_s [1:0] xclk;
   tcs_timer_pkg::tcs_pin_s [1:0] xrst;
   logic [1:0] cnt_ev;
   logic [1:0] clr_ev;
   logic [1:0] wr_cnt;
   logic [7:0] cnt_inc [2];
   logic acc_wr;
   logic [2:0] acc_reg;
   logic acc_ch;
   logic acc_ok;
   logic setup_ok;

   // Returns the register index addressed, or 3'h7 for any unmapped or unaligned address.
   function automatic logic [2:0] reg_index(input logic [7:0] a);
      logic [2:0] idx;
      idx = 3'h7;
      if (a[1:0] == 2'h0 && a[7:6] == 2'h0 && a[4:2] <= `TCS_OFF_CMPB) begin
         idx = a[4:2];
      end
      return idx;
   endfunction : reg_index

   // One-cycle tick at the rising or falling edge of presc bit (lg - 1), i.e. pclk / 2**lg.
   function automatic logic div_tick(input logic [12:0] presc, input logic [3:0] lg, input logic fall);
      logic [13:0] mask;
      logic [13:0] low;
      mask = 14'(14'h0001 << lg) - 14'h0001;
      low = {1'b0, presc} & mask;
      if (fall) begin
         return low == mask;
      end
      return low == (mask >> 1);
   endfunction : div_tick

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pins
         tcs_pin_sync u_clk_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pin(ext_clk_pin[gi]),
            .sync(xclk[gi])
         );
         tcs_pin_sync u_rst_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pin(ext_rst_pin[gi]),
            .sync(xrst[gi])
         );
      end
   endgenerate

   // The slave never inserts wait states; a bad address is flagged in the access phase.
   assign acc_reg = reg_index(paddr);
   assign acc_ch = paddr[`TCS_CH_BIT];
   assign acc_ok = acc_reg != 3'h7;
   assign setup_ok = psel & ~penable;
   assign acc_wr = psel & penable & pwrite & acc_ok;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~acc_ok;
   assign prdata = s_q.rdata;

   always_comb begin
      s_d = s_q;
      cnt_ev = 2'b00;
      clr_ev = 2'b00;
      wr_cnt = 2'b00;
      s_d.presc = s_q.presc + 13'h0001;
      for (int c = 0; c < 2; c++) begin
         case (s_q.ch[c].clk_src)
            tcs_timer_pkg::TCS_SRC_INT1: begin
               cnt_ev[c] = div_tick(s_q.presc, s_q.ch[c].int_clk[0] ? `TCS_LOG_DIV2 : `TCS_LOG_DIV8,
                                    s_q.ch[c].int_clk[1]);
            end
            tcs_timer_pkg::TCS_SRC_INT2: begin
               cnt_ev[c] = div_tick(s_q.presc, s_q.ch[c].int_clk[0] ? `TCS_LOG_DIV32 : `TCS_LOG_DIV64,
                                    s_q.ch[c].int_clk[1]);
            end
            tcs_timer_pkg::TCS_SRC_INT3: begin
               cnt_ev[c] = div_tick(s_q.presc, s_q.ch[c].int_clk[0] ? `TCS_LOG_DIV1024 : `TCS_LOG_DIV8192,
                                    s_q.ch[c].int_clk[1]);
            end
            tcs_timer_pkg::TCS_SRC_CASC: begin
               cnt_ev[c] = (c == 0) ? s_q.ch[1].ovf : s_q.ch[0].cma;
            end
            tcs_timer_pkg::TCS_SRC_XRIS: begin
               cnt_ev[c] = xclk[c].rise;
            end
            tcs_timer_pkg::TCS_SRC_XFAL: begin
               cnt_ev[c] = xclk[c].fall;
            end
            tcs_timer_pkg::TCS_SRC_XBTH: begin
               cnt_ev[c] = xclk[c].rise | xclk[c].fall;
            end
            default: begin
               cnt_ev[c] = 1'b0;
            end
         endcase
         case (s_q.ch[c].clr_src)
            tcs_timer_pkg::TCS_CLR_CMPA: begin
               clr_ev[c] = s_q.ch[c].cma;
            end
            tcs_timer_pkg::TCS_CLR_CMPB: begin
               clr_ev[c] = s_q.ch[c].cmb;
            end
            tcs_timer_pkg::TCS_CLR_EXT: begin
               clr_ev[c] = s_q.ch[c].ext_lvl ? xrst[c].level : xrst[c].rise;
            end
            default: begin
               clr_ev[c] = 1'b0;
            end
         endcase
         wr_cnt[c] = acc_wr && acc_ch == c[0] && acc_reg == `TCS_OFF_COUNT;
         // A software write wins over a clear, and a clear wins over a count event.
         // one step per event
         s_d.ch[c].ovf = cnt_ev[c] & ~clr_ev[c] & ~wr_cnt[c] & (s_q.ch[c].count == 8'hFF);
         s_d.ch[c].cma = cnt_ev[c] & ~clr_ev[c] & ~wr_cnt[c] & (cnt_inc[c] == s_q.ch[c].cmp_a);
         s_d.ch[c].cmb = cnt_ev[c] & ~clr_ev[c] & ~wr_cnt[c] & (cnt_inc[c] == s_q.ch[c].cmp_b);
         if (wr_cnt[c]) begin
            s_d.ch[c].count = pwdata[7:0];
         end else if (clr_ev[c]) begin
            s_d.ch[c].count = `TCS_RST_COUNT;
         end else if (cnt_ev[c]) begin
            s_d.ch[c].count = cnt_inc[c];
         end
         if (acc_wr && acc_ch == c[0]) begin
            case (acc_reg)
               `TCS_OFF_CTRL: begin
                  s_d.ch[c].irq_en = pwdata[`TCS_CTRL_IRQ_LSB +: 3];
                  s_d.ch[c].clr_src = tcs_timer_pkg::tcs_clr_e'(pwdata[`TCS_CTRL_CLR_LSB +: 2]);
                  s_d.ch[c].clk_src = tcs_timer_pkg::tcs_src_e'(pwdata[`TCS_CTRL_SRC_LSB +: 3]);
               end
               `TCS_OFF_CLKCTRL: begin
                  s_d.ch[c].ext_lvl = pwdata[`TCS_CCC_LVL_BIT];
                  s_d.ch[c].int_clk = pwdata[`TCS_CCC_ICK_LSB +: 2];
               end
               `TCS_OFF_CMPA: begin
                  s_d.ch[c].cmp_a = pwdata[7:0];
               end
               `TCS_OFF_CMPB: begin
                  s_d.ch[c].cmp_b = pwdata[7:0];
               end
               default: begin
               end
            endcase
         end
      end
      // Read data is captured in the setup cycle so that it stands registered through the access.
      if (setup_ok && !pwrite) begin
         s_d.rdata = 32'h0000_0000;
         case (acc_reg)
            `TCS_OFF_CTRL: begin
               s_d.rdata[7:0] = {s_q.ch[acc_ch].irq_en, s_q.ch[acc_ch].clr_src, s_q.ch[acc_ch].clk_src};
            end
            `TCS_OFF_CLKCTRL: begin
               s_d.rdata[7:0] = {4'h0, s_q.ch[acc_ch].ext_lvl, 1'b0, s_q.ch[acc_ch].int_clk};
            end
            `TCS_OFF_COUNT: begin
               s_d.rdata[7:0] = s_q.ch[acc_ch].count;
            end
            `TCS_OFF_CMPA: begin
               s_d.rdata[7:0] = s_q.ch[acc_ch].cmp_a;
            end
            `TCS_OFF_CMPB: begin
               s_d.rdata[7:0] = s_q.ch[acc_ch].cmp_b;
            end
            default: begin
               s_d.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   generate
      for (gi = 0; gi < 2; gi++) begin : g_inc
         assign cnt_inc[gi] = s_q.ch[gi].count + 8'h01;
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.presc <= 13'h0000;
         s_q.rdata <= 32'h0000_0000;
         for (int c = 0; c < 2; c++) begin
            s_q.ch[c] <= {`TCS_RST_CTRL, 3'h0, `TCS_RST_COUNT, `TCS_RST_CMP, `TCS_RST_CMP, 3'h0};
         end
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Reads of the clock control register never expose the reserved bits.
   a_ccc_rsv_hi: assert property (
      (setup_ok && !pwrite && acc_reg == `TCS_OFF_CLKCTRL) |=> (prdata[7:4] == 4'h0 && prdata[31:8] == 24'h0))
      else $error("reserved clock control bits 7..4 read nonzero");

   a_ccc_rsv_b2: assert property (
      (setup_ok && !pwrite && acc_reg == `TCS_OFF_CLKCTRL) |=> (prdata[2] == 1'b0))
      else $error("reserved clock control bit 2 read nonzero");

   // A reset pin only clears when the external clear mode is chosen.
   a_rst_ignored: assert property (
      (s_q.ch[1].clr_src != tcs_timer_pkg::TCS_CLR_EXT && s_q.ch[1].clk_src == tcs_timer_pkg::TCS_SRC_NONE
       && !s_q.ch[1].cma && !s_q.ch[1].cmb && !wr_cnt[1]) |=> $stable(s_q.ch[1].count))
      else $error("channel 1 count changed with no source and no external clear");

   a_rst_edge: assert property (
      (s_q.ch[1].clr_src == tcs_timer_pkg::TCS_CLR_EXT && !s_q.ch[1].ext_lvl && xrst[1].rise && !wr_cnt[1])
      |=> (s_q.ch[1].count == 8'h00))
      else $error("rising external reset did not clear channel 1");

   a_rst_level: assert property (
      (s_q.ch[1].clr_src == tcs_timer_pkg::TCS_CLR_EXT && s_q.ch[1].ext_lvl && xrst[1].level && !wr_cnt[1])
      |=> (s_q.ch[1].count == 8'h00))
      else $error("high external reset did not hold channel 1 cleared");

   a_div8_rise: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_INT1 && s_q.ch[0].int_clk == 2'b00 && cnt_ev[0])
      |-> (s_q.presc[2:0] == 3'h3))
      else $error("divide by 8 rising tick at wrong prescaler phase");

   a_div64_fall: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_INT2 && s_q.ch[0].int_clk == 2'b10 && cnt_ev[0])
      |-> (s_q.presc[5:0] == 6'h3F))
      else $error("divide by 64 falling tick at wrong prescaler phase");

   a_div1024_fall: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_INT3 && s_q.ch[0].int_clk == 2'b11 && cnt_ev[0])
      |-> (s_q.presc[9:0] == 10'h3FF))
      else $error("divide by 1024 falling tick at wrong prescaler phase");

   a_casc_ovf: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_CASC && s_q.ch[1].ovf && !clr_ev[0] && !wr_cnt[0])
      |=> (s_q.ch[0].count == $past(s_q.ch[0].count) + 8'h01))
      else $error("channel 0 missed a channel 1 overflow");

   a_casc_cma: assert property (
      (s_q.ch[1].clk_src == tcs_timer_pkg::TCS_SRC_CASC) |-> (cnt_ev[1] == s_q.ch[0].cma))
      else $error("channel 1 cascade event differs from channel 0 match A");

   a_ext_both: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_XBTH && (xclk[0].rise || xclk[0].fall)
       && !clr_ev[0] && !wr_cnt[0]) |=> (s_q.ch[0].count == $past(cnt_inc[0])))
      else $error("channel 0 missed an external clock edge");

   a_ext_fall: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_XFAL) |-> (cnt_ev[0] == xclk[0].fall))
      else $error("channel 0 falling-edge count event mismatch");

   a_ext_rise: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_XRIS) |-> (cnt_ev[0] == xclk[0].rise))
      else $error("channel 0 rising-edge count event mismatch");

   a_div2_fall: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_INT1 && s_q.ch[0].int_clk == 2'b11 && cnt_ev[0])
      |-> (s_q.presc[0] == 1'b1))
      else $error("divide by 2 falling tick at wrong prescaler phase");

   a_div32_rise: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_INT2 && s_q.ch[0].int_clk == 2'b01 && cnt_ev[0])
      |-> (s_q.presc[4:0] == 5'h0F))
      else $error("divide by 32 rising tick at wrong prescaler phase");

   a_div8192_rise: assert property (
      (s_q.ch[0].clk_src == tcs_timer_pkg::TCS_SRC_INT3 && s_q.ch[0].int_clk == 2'b00 && cnt_ev[0])
      |-> (s_q.presc == 13'h0FFF))
      else $error("divide by 8192 rising tick at wrong prescaler phase");

   // Every qualified event moves the count by exactly one, whatever the source.
   a_count_step: assert property (
      (cnt_ev[0] && !clr_ev[0] && !wr_cnt[0]) |=> (s_q.ch[0].count == $past(cnt_inc[0])))
      else $error("channel 0 count did not step by one");

   a_casc_inc: assert property (
      (s_q.ch[1].clk_src == tcs_timer_pkg::TCS_SRC_CASC && s_q.ch[0].cma && !clr_ev[1] && !wr_cnt[1])
      |=> (s_q.ch[1].count == $past(cnt_inc[1])))
      else $error("channel 1 missed a channel 0 match A");

endmodule : tcs_timer
`default_nettype wire

// ==== test/tcs_timer_tb.sv ====
// Self-checking bench for the two-channel timer clock-select block.
// Assumes the APB map of tcs_timer_regs.svh and pins synchronised to pclk.
`include "tcs_timer_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] ext_clk_pin = 2'h0;
   logic [1:0] ext_rst_pin = 2'h0;
   integer seed = 92;
   int fails = 0;
   int total_checks = 0;
   logic [31:0] rv;
   logic ev;
   logic [7:0] a0;
   logic [7:0] a1;
   int n;
   int dv;
   int k;

   tcs_timer i_tcs_timer (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ext_clk_pin(ext_clk_pin),
      .ext_rst_pin(ext_rst_pin)
   );

   always #10 pclk = ~pclk;

   task automatic results();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_reg

   task automatic check_err(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_err

   // The idle cycle at the end keeps psel from being assigned twice in one step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 16);
      if (pready !== 1'b1) begin
         fails++;
         results();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   function automatic logic [7:0] adr(input int ch, input logic [2:0] off);
      return 8'(ch << `TCS_CH_BIT) | {3'h0, off, 2'h0};
   endfunction : adr

   task automatic wr(input int ch, input logic [2:0] off, input logic [7:0] v);
      apb(1'b1, adr(ch, off), {24'h000000, v});
   endtask : wr

   task automatic rd(input int ch, input logic [2:0] off);
      apb(1'b0, adr(ch, off), 32'h00000000);
   endtask : rd

   // pins driven as inputs.
   // Each level is held four cycles so the synchroniser never drops an edge.
   task automatic pulse(input int ch, input int cnt);
      repeat (cnt) begin
         ext_clk_pin[ch] <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_clk_pin[ch] <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask : pulse

   function automatic int divisor(input int src, input int ick);
      case (src)
         1: return ick[0] ? 2 : 8;
         2: return ick[0] ? 32 : 64;
         default: return ick[0] ? 1024 : 8192;
      endcase
   endfunction : divisor

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int c = 0; c < 2; c++) begin
         rd(c, `TCS_OFF_CTRL);
         check_reg(rv, 32'h00000000);
         rd(c, `TCS_OFF_CLKCTRL);
         check_reg(rv, 32'h00000000);
         rd(c, `TCS_OFF_CMPA);
         check_reg(rv, 32'h000000FF);
         repeat (3) begin
            a0 = 8'($random(seed));
            apb(1'b1, adr(c, `TCS_OFF_CLKCTRL), {24'($random(seed)), a0});
            rd(c, `TCS_OFF_CLKCTRL);
            check_reg(rv, {24'h000000, a0 & 8'h0B});
         end
         wr(c, `TCS_OFF_CLKCTRL, 8'h00);
      end
      rd(0, 3'h5);
      check_err(ev, 1'b1);
      check_reg(rv, 32'h00000000);
      // Count rate over a window of whole divider periods is exact for either edge.
      for (int s = 0; s < 4; s++) begin
         for (int i = 0; i < 4; i++) begin
            wr(0, `TCS_OFF_CLKCTRL, 8'(i));
            wr(0, `TCS_OFF_CTRL, 8'(s));
            dv = (s == 0) ? 64 : divisor(s, i);
            k = (dv > 1024) ? 2 : (dv == 1024) ? 4 : (dv > 8) ? 20 : 50;
            rd(0, `TCS_OFF_COUNT);
            a0 = rv[7:0];
            repeat (k * dv - 3) @(posedge pclk);
            rd(0, `TCS_OFF_COUNT);
            check_reg({24'h000000, 8'(rv[7:0] - a0)}, 32'((s == 0) ? 0 : k));
         end
      end
      for (int s = 5; s < 8; s++) begin
         wr(0, `TCS_OFF_CTRL, 8'(s));
         n = 1 + ($random(seed) & 3);
         rd(0, `TCS_OFF_COUNT);
         a0 = rv[7:0];
         pulse(0, n);
         rd(0, `TCS_OFF_COUNT);
         check_reg({24'h000000, 8'(rv[7:0] - a0)}, 32'((s == 7) ? 2 * n : n));
      end
      a1 = 8'($random(seed)) | 8'h01;
      wr(1, `TCS_OFF_CTRL, 8'h18);
      wr(1, `TCS_OFF_COUNT, a1);
      ext_rst_pin[1] <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(1, `TCS_OFF_COUNT);
      check_reg(rv, 32'h00000000);
      wr(1, `TCS_OFF_COUNT, a1);
      repeat (8) @(posedge pclk);
      rd(1, `TCS_OFF_COUNT);
      check_reg(rv, {24'h000000, a1});
      ext_rst_pin[1] <= 1'b0;
      wr(1, `TCS_OFF_CLKCTRL, 8'h08);
      ext_rst_pin[1] <= 1'b1;
      repeat (8) @(posedge pclk);
      wr(1, `TCS_OFF_COUNT, a1);
      rd(1, `TCS_OFF_COUNT);
      check_reg(rv, 32'h00000000);
      ext_rst_pin[1] <= 1'b0;
      repeat (8) @(posedge pclk);
      wr(1, `TCS_OFF_COUNT, a1);
      rd(1, `TCS_OFF_COUNT);
      check_reg(rv, {24'h000000, a1});
      wr(1, `TCS_OFF_CTRL, 8'h00);
      ext_rst_pin[1] <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(1, `TCS_OFF_COUNT);
      check_reg(rv, {24'h000000, a1});
      ext_rst_pin[1] <= 1'b0;
      // Never cascade both channels at once.
      wr(1, `TCS_OFF_CTRL, 8'h05);
      wr(1, `TCS_OFF_COUNT, 8'hFE);
      a0 = 8'($random(seed));
      wr(0, `TCS_OFF_COUNT, a0);
      wr(0, `TCS_OFF_CTRL, 8'h04);
      pulse(1, 2);
      rd(0, `TCS_OFF_COUNT);
      check_reg(rv, {24'h000000, 8'(a0 + 8'h01)});
      rd(1, `TCS_OFF_COUNT);
      check_reg(rv, 32'h00000000);
      wr(0, `TCS_OFF_CTRL, 8'h05);
      wr(0, `TCS_OFF_CMPA, 8'h03);
      wr(0, `TCS_OFF_COUNT, 8'h00);
      wr(1, `TCS_OFF_COUNT, a1);
      wr(1, `TCS_OFF_CTRL, 8'h04);
      pulse(0, 4);
      rd(0, `TCS_OFF_COUNT);
      check_reg(rv, 32'h00000004);
      rd(1, `TCS_OFF_COUNT);
      check_reg(rv, {24'h000000, 8'(a1 + 8'h01)});
      results();
   end
endmodule : testbench
`default_nettype wire
